// >>> rtl/flash_ram_access_guard.sv
// Access guard for flash, RAM and configuration spaces with its register port
`include "access_guard_map.svh"
module flash_ram_access_guard (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic req_valid_i,
	input wire logic [1:0] req_target_i,
	input wire logic [19:0] req_addr_i,
	input wire logic [1:0] req_kind_i,
	input wire logic req_secure_i,
	input wire logic req_from_core_i,
	input wire logic req_factory_i,
	input wire logic debug_active_i,
	input wire logic [31:0] req_wdata_i,
	input wire logic [31:0] mem_rdata_i,
	output logic mem_valid_o,
	output logic [19:0] mem_addr_o,
	output logic [1:0] mem_kind_o,
	output logic [31:0] mem_wdata_o,
	output logic [31:0] resp_rdata_o,
	output logic resp_valid_o,
	output logic resp_error_o,
	output logic security_violation_fault_o,
	output logic bus_access_fault_o,
	output logic flash_violation_event_o,
	output logic ram_violation_event_o,
	output logic irq_o
);
	access_guard_pkg::perm_t flash_perm_r [32];
	access_guard_pkg::perm_t ram_perm_r [32];
	logic [31:0] flash_lock_r;
	logic [31:0] ram_lock_r;
	logic [4:0] flash_nsc_sel_r [2];
	logic [4:0] flash_nsc_size_r [2];
	logic [4:0] ram_nsc_sel_r [2];
	logic [4:0] ram_nsc_size_r [2];
	logic flash_evt_r;
	logic ram_evt_r;
	logic [1:0] inten_r;
	logic rd_pend_r;
	logic blocked_rd_r;
	logic [31:0] reg_rdata_nxt;
	logic [4:0] idx;
	access_guard_pkg::perm_t perm;
	logic [4:0] flash_idx;
	logic [4:0] ram_idx;
	logic [14:0] flash_offs;
	logic [12:0] ram_offs;
	logic flash_in_nsc;
	logic ram_in_nsc;
	logic in_nsc;
	logic sec_viol;
	logic rwx_viol;
	logic viol;
	logic wr_ok_flash;
	logic wr_ok_ram;
	logic flash_hit;
	logic ram_hit;
	logic cfg_hit;

	// Region index and offset come straight from the transfer address
	assign flash_idx = req_addr_i[19:15];
	assign flash_offs = req_addr_i[14:0];
	assign ram_idx = req_addr_i[17:13];
	assign ram_offs = req_addr_i[12:0];

	// Flash callable area, sized in 1 KiB steps
	callable_window #(
		.offs_w(`AG_FLASH_REGION_LSB),
		.unit_w(`AG_NSC_UNIT_FLASH)
	) flash_window_inst (
		.idx_i(flash_idx),
		.offs_i(flash_offs),
		.secure_i(flash_perm_r[flash_idx][3]),
		.sel0_i(flash_nsc_sel_r[0]),
		.size0_i(flash_nsc_size_r[0]),
		.sel1_i(flash_nsc_sel_r[1]),
		.size1_i(flash_nsc_size_r[1]),
		.in_nsc_o(flash_in_nsc)
	);

	// RAM callable area, sized in 256 byte steps
	callable_window #(
		.offs_w(`AG_RAM_REGION_LSB),
		.unit_w(`AG_NSC_UNIT_RAM)
	) ram_window_inst (
		.idx_i(ram_idx),
		.offs_i(ram_offs),
		.secure_i(ram_perm_r[ram_idx][3]),
		.sel0_i(ram_nsc_sel_r[0]),
		.size0_i(ram_nsc_size_r[0]),
		.sel1_i(ram_nsc_sel_r[1]),
		.size1_i(ram_nsc_size_r[1]),
		.in_nsc_o(ram_in_nsc)
	);

	// Permission lookup and violation classification
	always_comb begin
		idx = 5'h00;
		perm = 4'h0;
		in_nsc = 1'b0;
		sec_viol = 1'b0;
		rwx_viol = 1'b0;
		flash_hit = req_target_i == 2'(access_guard_pkg::mem_flash);
		ram_hit = req_target_i == 2'(access_guard_pkg::mem_ram);
		cfg_hit = req_target_i == 2'(access_guard_pkg::mem_config);
		if (flash_hit) begin
			idx = flash_idx;
			perm = flash_perm_r[idx];
			in_nsc = flash_in_nsc;
		end else if (ram_hit) begin
			idx = ram_idx;
			perm = ram_perm_r[idx];
			in_nsc = ram_in_nsc;
		end
		if (flash_hit || ram_hit) begin
			// Callable area lets non-secure fetches in, the entry point itself
			sec_viol = perm[3] && !req_secure_i &&
				!(in_nsc && req_kind_i == 2'(access_guard_pkg::acc_fetch));
			case (req_kind_i)
				2'(access_guard_pkg::acc_read): rwx_viol = !perm[2];
				2'(access_guard_pkg::acc_write): rwx_viol = !perm[1];
				default: rwx_viol = !perm[0];
			endcase
		end else if (cfg_hit) begin
			sec_viol = !req_secure_i;
			rwx_viol = (req_factory_i && req_kind_i == 2'(access_guard_pkg::acc_write)) ||
				(req_kind_i == 2'(access_guard_pkg::acc_fetch) && !debug_active_i);
		end
		viol = req_valid_i && (sec_viol || rwx_viol);
	end

	// Forwarded transfer; a blocked one never reaches memory
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_valid_o <= 1'b0;
			mem_addr_o <= 20'h00000;
			mem_kind_o <= 2'h0;
			mem_wdata_o <= 32'h00000000;
		end else begin
			mem_valid_o <= req_valid_i && !viol;
			mem_addr_o <= req_addr_i;
			mem_kind_o <= req_kind_i;
			// Zeroed too, so an ignored write cannot leak data downstream
			mem_wdata_o <= viol ? 32'h00000000 : req_wdata_i;
		end
	end

	// Response and error line back to the initiating master
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			resp_valid_o <= 1'b0;
			resp_error_o <= 1'b0;
		end else begin
			resp_valid_o <= req_valid_i;
			resp_error_o <= viol;
		end
	end

	// Core faults; a security breach hides any permission breach
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			security_violation_fault_o <= 1'b0;
			bus_access_fault_o <= 1'b0;
		end else begin
			security_violation_fault_o <= viol && req_from_core_i && sec_viol;
			bus_access_fault_o <= viol && req_from_core_i && !sec_viol;
		end
	end

	// Read tracking, so read data can be forced one cycle later
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_pend_r <= 1'b0;
			blocked_rd_r <= 1'b0;
		end else begin
			rd_pend_r <= req_valid_i && req_kind_i != 2'(access_guard_pkg::acc_write);
			blocked_rd_r <= viol;
		end
	end

	// Read data is forced to zero for a blocked read
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			resp_rdata_o <= 32'h00000000;
		end else if (rd_pend_r) begin
			resp_rdata_o <= blocked_rd_r ? 32'h00000000 : mem_rdata_i;
		end
	end

	// Sticky flash event; set wins over a clear in the same cycle
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flash_evt_r <= 1'b0;
		end else if (viol && flash_hit && !(req_from_core_i && sec_viol)) begin
			flash_evt_r <= 1'b1;
		end else if (reg_wr_i && reg_addr_i == `AG_EVENT_FLASH && !reg_wdata_i[0]) begin
			flash_evt_r <= 1'b0;
		end
	end

	// Sticky RAM event; set wins over a clear in the same cycle
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ram_evt_r <= 1'b0;
		end else if (viol && ram_hit && !(req_from_core_i && sec_viol)) begin
			ram_evt_r <= 1'b1;
		end else if (reg_wr_i && reg_addr_i == `AG_EVENT_RAM && !reg_wdata_i[0]) begin
			ram_evt_r <= 1'b0;
		end
	end

	// Interrupt lags its event by one cycle, traded for a registered output
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= (flash_evt_r && inten_r[0]) || (ram_evt_r && inten_r[1]);
		end
	end
	assign flash_violation_event_o = flash_evt_r;
	assign ram_violation_event_o = ram_evt_r;

	// Permission and lock registers
	assign wr_ok_flash = reg_wr_i && reg_addr_i[11:7] == 5'h00;
	assign wr_ok_ram = reg_wr_i && reg_addr_i[11:7] == 5'h01;
	// Flash region table; a locked entry ignores writes until reset
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 32; i++) begin
				flash_perm_r[i] <= `AG_PERM_RESET;
			end
			flash_lock_r <= 32'h00000000;
		end else if (wr_ok_flash && !flash_lock_r[reg_addr_i[6:2]]) begin
			flash_perm_r[reg_addr_i[6:2]] <= {reg_wdata_i[`AG_PERM_SECURE],
				reg_wdata_i[`AG_PERM_READ:`AG_PERM_EXEC]};
			flash_lock_r[reg_addr_i[6:2]] <= reg_wdata_i[`AG_PERM_LOCK];
		end
	end

	// RAM region table; a locked entry ignores writes until reset
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 32; i++) begin
				ram_perm_r[i] <= `AG_PERM_RESET;
			end
			ram_lock_r <= 32'h00000000;
		end else if (wr_ok_ram && !ram_lock_r[reg_addr_i[6:2]]) begin
			ram_perm_r[reg_addr_i[6:2]] <= {reg_wdata_i[`AG_PERM_SECURE],
				reg_wdata_i[`AG_PERM_READ:`AG_PERM_EXEC]};
			ram_lock_r[reg_addr_i[6:2]] <= reg_wdata_i[`AG_PERM_LOCK];
		end
	end

	// Flash sub-region descriptors; they are not covered by region locks
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `AG_NSC_DESC; i++) begin
				flash_nsc_sel_r[i] <= 5'h00;
				flash_nsc_size_r[i] <= 5'h00;
			end
		end else if (reg_wr_i && reg_addr_i[11:3] == 9'(`AG_FLASH_NSC_BASE >> 3)) begin
			flash_nsc_sel_r[reg_addr_i[2]] <= reg_wdata_i[4:0];
			flash_nsc_size_r[reg_addr_i[2]] <= reg_wdata_i[`AG_NSC_SIZE_LSB +: 5];
		end
	end

	// RAM sub-region descriptors
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `AG_NSC_DESC; i++) begin
				ram_nsc_sel_r[i] <= 5'h00;
				ram_nsc_size_r[i] <= 5'h00;
			end
		end else if (reg_wr_i && reg_addr_i[11:3] == 9'(`AG_RAM_NSC_BASE >> 3)) begin
			ram_nsc_sel_r[reg_addr_i[2]] <= reg_wdata_i[4:0];
			ram_nsc_size_r[reg_addr_i[2]] <= reg_wdata_i[`AG_NSC_SIZE_LSB +: 5];
		end
	end

	// Interrupt enable
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			inten_r <= 2'h0;
		end else if (reg_wr_i && reg_addr_i == `AG_INTEN) begin
			inten_r <= reg_wdata_i[1:0];
		end
	end

	// Register read-back; unmapped addresses read zero
	always_comb begin
		reg_rdata_nxt = 32'h00000000;
		if (reg_addr_i[11:7] == 5'h00) begin
			reg_rdata_nxt = {23'h0, flash_lock_r[reg_addr_i[6:2]], 3'h0,
				flash_perm_r[reg_addr_i[6:2]][3], 1'b0, flash_perm_r[reg_addr_i[6:2]][2:0]};
		end else if (reg_addr_i[11:7] == 5'h01) begin
			reg_rdata_nxt = {23'h0, ram_lock_r[reg_addr_i[6:2]], 3'h0,
				ram_perm_r[reg_addr_i[6:2]][3], 1'b0, ram_perm_r[reg_addr_i[6:2]][2:0]};
		end else if (reg_addr_i[11:3] == 9'(`AG_FLASH_NSC_BASE >> 3)) begin
			reg_rdata_nxt = {19'h0, flash_nsc_size_r[reg_addr_i[2]], 3'h0,
				flash_nsc_sel_r[reg_addr_i[2]]};
		end else if (reg_addr_i[11:3] == 9'(`AG_RAM_NSC_BASE >> 3)) begin
			reg_rdata_nxt = {19'h0, ram_nsc_size_r[reg_addr_i[2]], 3'h0,
				ram_nsc_sel_r[reg_addr_i[2]]};
		end else if (reg_addr_i == `AG_EVENT_FLASH) begin
			reg_rdata_nxt = {31'h0, flash_evt_r};
		end else if (reg_addr_i == `AG_EVENT_RAM) begin
			reg_rdata_nxt = {31'h0, ram_evt_r};
		end else if (reg_addr_i == `AG_INTEN) begin
			reg_rdata_nxt = {30'h0, inten_r};
		end else if (reg_addr_i == `AG_STATUS) begin
			reg_rdata_nxt = {30'h0, ram_evt_r && inten_r[1], flash_evt_r && inten_r[0]};
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= reg_rdata_nxt;
		end
	end
endmodule

// Callable sub-region test for one memory: top of the selected region, growing down
module callable_window #(
	parameter int offs_w = 15,
	parameter int unit_w = 10
) (
	input wire logic [4:0] idx_i,
	input wire logic [offs_w-1:0] offs_i,
	input wire logic secure_i,
	input wire logic [4:0] sel0_i,
	input wire logic [4:0] size0_i,
	input wire logic [4:0] sel1_i,
	input wire logic [4:0] size1_i,
	output logic in_nsc_o
);
	logic [4:0] size0;
	logic [4:0] size1;
	logic [4:0] nsc_size;
	logic [offs_w-1:0] span;
	logic [offs_w-1:0] limit;

	// A descriptor only counts for the region it selects
	assign size0 = sel0_i == idx_i ? size0_i : 5'h00;
	assign size1 = sel1_i == idx_i ? size1_i : 5'h00;
	// Two descriptors on one region merge into the larger area
	assign nsc_size = size0 > size1 ? size0 : size1;
	// Size field times the step width; five size bits fill the offset
	assign span = offs_w'({nsc_size, {unit_w{1'b0}}});
	assign limit = {offs_w{1'b1}} - span;
	// A non-secure region never gets a callable area
	assign in_nsc_o = secure_i && nsc_size != 5'h00 && offs_i > limit;
endmodule

// >>> rtl/access_guard_map.svh
// Register offsets, field positions, reset values and sizes of the access guard
// Functional notes
// - A violating flash or RAM transfer is blocked and never reaches memory.
// - A blocked read returns all-zero read data.
// - A violation drives the bus error line back to the initiating master.
// - Core security breach on flash or RAM raises security violation fault.
// - Core read/write/execute breach raises bus access fault plus memory event.
// - Flash violation event for every flash violation except core security breach.
// - RAM violation event for every RAM violation except core security breach.
// - Non-core masters get read-zero/write-ignore and the memory event.
// - Core security breach with another breach reports only the security fault.
// - Each violation event can raise an interrupt under an enable bit.
// - Factory and user configuration spaces are always secure.
// - Factory info space is read only; writes are violations.
// - User config space allows secure reads and writes only.
// - Fetch from config spaces is a violation unless debug is active.
// - RAM splits into 32 regions of 8 KiB, indexed by upper address bits.
// - Reads check read, writes check write, fetches check execute only.
// - Secure region accepts only secure transfers.
// - Region lock bit freezes that region's permissions until reset.
// - Callable sub-region sits at top of selected region, growing down.
// - Callable sub-region exists only with non-zero size and secure region.
// - Two descriptors on one region give one sub-region of the larger size.
// - Descriptor on non-secure region creates nothing; region stays non-secure.
// - Flash splits into 32 regions of 32 KiB; write permission governs erase.
// - Flash callable sub-regions follow the same rules as RAM ones.
`ifndef ACCESS_GUARD_MAP_SVH
`define ACCESS_GUARD_MAP_SVH
`define AG_FLASH_REGION_BASE 12'h000
`define AG_RAM_REGION_BASE 12'h080
`define AG_FLASH_NSC_BASE 12'h100
`define AG_RAM_NSC_BASE 12'h110
`define AG_EVENT_FLASH 12'h200
`define AG_EVENT_RAM 12'h204
`define AG_INTEN 12'h208
`define AG_STATUS 12'h20c
`define AG_PERM_EXEC 0
`define AG_PERM_WRITE 1
`define AG_PERM_READ 2
`define AG_PERM_SECURE 4
`define AG_PERM_LOCK 8
`define AG_PERM_RESET 4'h7
`define AG_NSC_SIZE_LSB 8
`define AG_FLASH_REGION_LSB 15
`define AG_RAM_REGION_LSB 13
`define AG_NSC_UNIT_FLASH 10
`define AG_NSC_UNIT_RAM 8
`define AG_NSC_DESC 2
`endif

// >>> rtl/access_guard_pkg.sv
// Types shared by the access guard
package access_guard_pkg;
	typedef enum logic [1:0] {
		acc_read,
		acc_write,
		acc_fetch
	} acc_kind_t;
	typedef enum logic [1:0] {
		mem_none,
		mem_flash,
		mem_ram,
		mem_config
	} mem_target_t;
	typedef logic [3:0] perm_t;
endpackage

// >>> bench/access_guard_assertions.sv
// Port-level checks of the access guard
module access_guard_checker (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input wire logic [1:0] req_target_i,
	input wire logic [1:0] req_kind_i,
	input wire logic req_from_core_i,
	input wire logic mem_valid_o,
	input wire logic [31:0] resp_rdata_o,
	input wire logic resp_valid_o,
	input wire logic resp_error_o,
	input wire logic security_violation_fault_o,
	input wire logic bus_access_fault_o,
	input wire logic flash_violation_event_o,
	input wire logic ram_violation_event_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_answer; req_valid_i |=> resp_valid_o; endproperty
	a_answer: assert property (p_answer) else $error("missing response");
	property p_block; resp_valid_o |-> mem_valid_o != resp_error_o; endproperty
	a_block: assert property (p_block) else $error("blocked transfer forwarded");
	property p_zero; resp_error_o && $past(req_kind_i) != 2'h1 |=> resp_rdata_o == 32'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("blocked read leaks data");
	property p_sec; security_violation_fault_o |-> resp_error_o && $past(req_from_core_i);
	endproperty
	a_sec: assert property (p_sec) else $error("bad security fault");
	property p_bus; bus_access_fault_o |-> resp_error_o && !security_violation_fault_o;
	endproperty
	a_bus: assert property (p_bus) else $error("bad bus fault");
	// Non-core masters only see the error line, never a core fault
	property p_dma; resp_error_o && !$past(req_from_core_i) |-> !(security_violation_fault_o
		|| bus_access_fault_o); endproperty
	a_dma: assert property (p_dma) else $error("fault for non-core master");
	property p_fev; $rose(flash_violation_event_o) |-> resp_error_o && $past(req_target_i) == 2'h1;
	endproperty
	a_fev: assert property (p_fev) else $error("flash event without cause");
	property p_rev; $rose(ram_violation_event_o) |-> resp_error_o && $past(req_target_i) == 2'h2;
	endproperty
	a_rev: assert property (p_rev) else $error("ram event without cause");
endmodule
bind flash_ram_access_guard access_guard_checker access_guard_checker_inst (.core_clk_i, .rst_i,
	.req_valid_i, .req_target_i, .req_kind_i, .req_from_core_i, .mem_valid_o, .resp_rdata_o,
	.resp_valid_o, .resp_error_o, .security_violation_fault_o, .bus_access_fault_o,
	.flash_violation_event_o, .ram_violation_event_o);

// >>> bench/guard_mem_model.sv
// Behavioural memory behind the access guard
module guard_mem_model (
	input wire logic clk_i,
	input wire logic valid_i,
	input wire logic [19:0] addr_i,
	output logic [31:0] rdata_o
);
	logic [31:0] last_r;
	// Idle bus shows the inverse of its last value, so stale data never passes
	assign rdata_o = valid_i ? ({12'h000, addr_i} ^ 32'ha5a50000) : ~last_r;
	always_ff @(posedge clk_i) begin
		last_r <= rdata_o;
	end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench of the access guard
`include "access_guard_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] reg_addr_i = 12'h000;
	logic [31:0] reg_wdata_i = 32'h0, req_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, req_valid_i = 1'b0, req_secure_i = 1'b0;
	logic req_from_core_i = 1'b0, req_factory_i = 1'b0, debug_active_i = 1'b0;
	logic [1:0] req_target_i = 2'h0, req_kind_i = 2'h0;
	logic [19:0] req_addr_i = 20'h0;
	logic [31:0] mem_rdata_i, reg_rdata_o, mem_wdata_o, resp_rdata_o;
	logic [19:0] mem_addr_o;
	logic [1:0] mem_kind_o;
	logic mem_valid_o, resp_valid_o, resp_error_o, security_violation_fault_o;
	logic bus_access_fault_o, flash_violation_event_o, ram_violation_event_o, irq_o;
	int err_count = 0, compares = 0;
	flash_ram_access_guard flash_ram_access_guard_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_valid_i(req_valid_i),
		.req_target_i(req_target_i), .req_addr_i(req_addr_i), .req_kind_i(req_kind_i),
		.req_secure_i(req_secure_i), .req_from_core_i(req_from_core_i),
		.req_factory_i(req_factory_i), .debug_active_i(debug_active_i),
		.req_wdata_i(req_wdata_i), .mem_rdata_i(mem_rdata_i), .mem_valid_o(mem_valid_o),
		.mem_addr_o(mem_addr_o), .mem_kind_o(mem_kind_o), .mem_wdata_o(mem_wdata_o),
		.resp_rdata_o(resp_rdata_o), .resp_valid_o(resp_valid_o), .resp_error_o(resp_error_o),
		.security_violation_fault_o(security_violation_fault_o),
		.bus_access_fault_o(bus_access_fault_o),
		.flash_violation_event_o(flash_violation_event_o),
		.ram_violation_event_o(ram_violation_event_o), .irq_o(irq_o));
	guard_mem_model guard_mem_model_inst (.clk_i(core_clk_i), .valid_i(mem_valid_o),
		.addr_i(mem_addr_o), .rdata_o(mem_rdata_i));
	always #2 core_clk_i = ~core_clk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, e);
	endtask
	// Expected code e is {error, security fault, bus fault}
	task automatic xf(input logic [1:0] t, input logic [19:0] a, input logic [1:0] k,
		input logic s, input logic c, input logic [2:0] e);
		@(posedge core_clk_i);
		req_valid_i <= 1'b1;
		req_target_i <= t;
		req_addr_i <= a;
		req_kind_i <= k;
		req_secure_i <= s;
		req_from_core_i <= c;
		req_wdata_i <= {12'h000, a} ^ 32'h5a5a0000;
		@(posedge core_clk_i);
		req_valid_i <= 1'b0;
		#1 chk({27'h0, resp_valid_o, mem_valid_o, resp_error_o, security_violation_fault_o,
			bus_access_fault_o}, {27'h0, 1'b1, ~e[2], e});
		chk(mem_wdata_o, e[2] ? 32'h0 : ({12'h000, a} ^ 32'h5a5a0000));
		chk({10'h0, mem_addr_o, mem_kind_o}, {10'h0, a, k});
		@(posedge core_clk_i);
		#1 if (k != 2'h1) chk(resp_rdata_o, e[2] ? 32'h0 : ({12'h000, a} ^ 32'ha5a50000));
	endtask
	task automatic t_perm;
		wr(`AG_RAM_REGION_BASE + 12'h00c, 32'h4);
		xf(2'h2, 20'h06010, 2'h0, 1'b0, 1'b0, 3'h0);
		xf(2'h2, 20'h06020, 2'h1, 1'b0, 1'b1, 3'h5);
		xf(2'h2, 20'h06030, 2'h2, 1'b0, 1'b0, 3'h4);
		rd(`AG_EVENT_RAM, 32'h1);
		wr(`AG_INTEN, 32'h2);
		rd(`AG_STATUS, 32'h2);
		chk({31'h0, irq_o}, 32'h1);
		wr(`AG_EVENT_RAM, 32'h0);
		rd(`AG_EVENT_RAM, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
	endtask
	task automatic t_sec;
		wr(`AG_FLASH_REGION_BASE + 12'h008, 32'h11);
		xf(2'h1, 20'h10040, 2'h1, 1'b0, 1'b1, 3'h6);
		rd(`AG_EVENT_FLASH, 32'h0);
		xf(2'h1, 20'h10044, 2'h0, 1'b0, 1'b0, 3'h4);
		rd(`AG_EVENT_FLASH, 32'h1);
		wr(`AG_INTEN, 32'h1);
		rd(`AG_STATUS, 32'h1);
		chk({31'h0, irq_o}, 32'h1);
		wr(`AG_FLASH_NSC_BASE, 32'h102);
		xf(2'h1, 20'h17c10, 2'h2, 1'b0, 1'b1, 3'h0);
		xf(2'h1, 20'h17b00, 2'h2, 1'b0, 1'b1, 3'h6);
		xf(2'h1, 20'h17ff0, 2'h2, 1'b1, 1'b1, 3'h0);
	endtask
	task automatic t_lock;
		wr(`AG_RAM_REGION_BASE + 12'h01c, 32'h104);
		wr(`AG_RAM_REGION_BASE + 12'h01c, 32'h7);
		rd(`AG_RAM_REGION_BASE + 12'h01c, 32'h104);
		xf(2'h2, 20'h0e000, 2'h1, 1'b0, 1'b0, 3'h4);
	endtask
	task automatic t_cfg;
		@(posedge core_clk_i);
		req_factory_i <= 1'b1;
		xf(2'h3, 20'h00010, 2'h1, 1'b1, 1'b0, 3'h4);
		xf(2'h3, 20'h00014, 2'h0, 1'b1, 1'b0, 3'h0);
		@(posedge core_clk_i);
		req_factory_i <= 1'b0;
		xf(2'h3, 20'h00018, 2'h0, 1'b0, 1'b0, 3'h4);
		xf(2'h3, 20'h0001c, 2'h1, 1'b1, 1'b0, 3'h0);
		xf(2'h3, 20'h00020, 2'h2, 1'b1, 1'b0, 3'h4);
		@(posedge core_clk_i);
		debug_active_i <= 1'b1;
		xf(2'h3, 20'h00024, 2'h2, 1'b1, 1'b0, 3'h0);
		@(posedge core_clk_i);
		debug_active_i <= 1'b0;
	endtask
	task automatic t_nsc;
		wr(`AG_RAM_REGION_BASE + 12'h010, 32'h17);
		wr(`AG_RAM_NSC_BASE, 32'h104);
		wr(`AG_RAM_NSC_BASE + 12'h004, 32'h204);
		xf(2'h2, 20'h09e10, 2'h2, 1'b0, 1'b1, 3'h0);
		xf(2'h2, 20'h09c00, 2'h2, 1'b0, 1'b1, 3'h6);
		xf(2'h2, 20'h09f00, 2'h0, 1'b0, 1'b1, 3'h6);
		wr(`AG_RAM_NSC_BASE + 12'h004, 32'h206);
		xf(2'h2, 20'h09e10, 2'h2, 1'b0, 1'b1, 3'h6);
		xf(2'h2, 20'h0dff0, 2'h0, 1'b0, 1'b1, 3'h0);
	endtask
	task automatic final_report;
		if (err_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Whole run needs well under a thousand cycles
	initial begin
		#20000;
		err_count++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(`AG_FLASH_REGION_BASE, 32'h7);
		rd(`AG_RAM_REGION_BASE + 12'h07c, 32'h7);
		rd(`AG_RAM_NSC_BASE, 32'h0);
		rd(12'h300, 32'h0);
		t_perm;
		t_sec;
		t_lock;
		t_cfg;
		t_nsc;
		final_report;
	end
endmodule
